// ===== mip_pkg.sv
// Overview of operation
// - Local inputs converted one after another
// - Decimate converter output, store in sample RAM
// - Remote pairs bypass mux into own decimator
// - Remote samples written directly, no mux slot
// - Eight current inputs form four configurable pairs
// - Preamp enable routes first pair via gain 8
// - First pair differential selectable on its own
// - Remote select turns pairs two-four digital
// - Remote select low keeps pairs two-four analog
// - First pair never becomes a remote link
// - Link carries data both ways plus power
// - Voltage inputs single-ended only
// - Frame starts at state one, runs count states, one when count is zero
// - Pair result in lower slot, upper untouched
package mip_pkg;
  localparam int          SAMPLE_W      = 22;
  localparam logic [6:0]  DEC_LEN       = 7'h40;   // Modulator bits per sample
  localparam logic [6:0]  STATE_LAST    = 7'h41;   // Last cycle of a mux state
  localparam logic [3:0]  SLOT_UNUSED   = 4'hf;    // Idle mux slot
  localparam logic [3:0]  SLOT_VOLT0    = 4'h8;    // First voltage slot
  localparam logic [3:0]  COUNT_MIN     = 4'h1;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          LINK_PULSE_NS = 160;     // Width of one drive phase
  localparam logic [3:0]  LINK_PULSE_CYC =
    4'((LINK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  LINK_SAMPLE_CYC = 4'hc;  // Reply sample point

  typedef enum logic {ST_START, ST_CONV} mip_phase_t;

  typedef struct packed {
    mip_phase_t                   phase;
    logic [3:0]                   fidx;
    logic [3:0]                   count;
    logic [6:0]                   cyc;
    logic                         rmt;
    logic                         pre;
    logic [3:0]                   diff;
    logic [15:0][3:0]             tbl;
    logic [2:0]                   sync1;
    logic [2:0]                   sync2;
    logic [3:0]                   lcyc;
    logic [2:0]                   pend;
    logic [2:0][SAMPLE_W-1:0]     pdata;
    logic [3:0]                   mux_sel;
    logic                         mux_diff;
    logic                         pre_route;
    logic                         frame_start;
    logic                         wr;
    logic [3:0]                   waddr;
    logic [SAMPLE_W-1:0]          wdata;
    logic [2:0]                   lout;
    logic [2:0]                   loe;
  } mip_state_t;

  typedef struct packed {
    logic [6:0]          nbits;
    logic [6:0]          ones;
    logic                sval;
    logic [SAMPLE_W-1:0] sample;
  } mip_dec_state_t;

  localparam mip_dec_state_t DEC_RESET = '0;

  // Ones count over a window to signed sample
  function automatic logic [SAMPLE_W-1:0] ones_to_sample(input logic [6:0] ones);
    logic [7:0] v;
    v = 8'({ones, 1'b0}) - {1'b0, DEC_LEN};
    return {{(SAMPLE_W-8){v[7]}}, v};
  endfunction
endpackage

// ===== mip_dec_if.sv
`timescale 1ns/1ps
interface mip_dec_if;
  import mip_pkg::*;
  logic                bit_valid;
  logic                bit_data;
  logic                clear;
  logic                sample_valid;
  logic [SAMPLE_W-1:0] sample;
  modport source (output bit_valid, bit_data, clear, input sample_valid, sample);
  modport filter (input bit_valid, bit_data, clear, output sample_valid, sample);
endinterface

// ===== mip_decimator.sv
`timescale 1ns/1ps
module mip_decimator
  import mip_pkg::*;
(
  input  wire logic clock_in,   // System clock
  input  wire logic rst_n_in,   // Async reset, active low
  mip_dec_if.filter dec         // Bit stream in, samples out
);
  mip_dec_state_t s;
  mip_dec_state_t next_s;

  // Boxcar FIR over a fixed window of modulator bits
  always_comb begin
    next_s = s;
    next_s.sval = 1'b0;
    if (dec.clear) begin
      next_s.nbits = '0;
      next_s.ones = '0;
    end else if (dec.bit_valid) begin
      next_s.nbits = s.nbits + 7'h1;
      next_s.ones = s.ones + {6'h0, dec.bit_data};
      if (next_s.nbits == DEC_LEN) begin
        next_s.sample = ones_to_sample(next_s.ones);
        next_s.sval = 1'b1;
        next_s.nbits = '0;
        next_s.ones = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= DEC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign dec.sample_valid = s.sval;
  assign dec.sample = s.sample;
endmodule

// ===== mip_input_path.sv
`timescale 1ns/1ps
module mip_input_path
  import mip_pkg::*;
(
  input  wire logic                clock_in,                         // 25 MHz clock
  input  wire logic                rst_n_in,                         // Async reset, low
  input  wire logic                preamp_enable_in,                 // Gain 8 on first pair
  input  wire logic                first_pair_differential_select_in,// First pair diff
  input  wire logic [2:0]          pair_differential_select_in,      // Pairs 2..4 diff
  input  wire logic                remote_sensor_select_in,          // Pairs 2..4 remote
  input  wire logic [3:0]          mux_state_count_in,               // States per frame
  input  wire logic                adc_bit_in,                       // Converter bits
  input  wire logic [2:0]          link_in,                          // Link pin level
  input  wire logic [2:0]          link_command_in,                  // Downlink bits
  output logic      [3:0]          mux_select_out,                   // Input slot, f idle
  output logic                     mux_differential_out,             // Pair as diff
  output logic                     preamp_route_out,                 // Via preamp
  output logic                     frame_start_out,                  // Frame start pulse
  output logic                     ram_write_out,                    // Sample RAM write
  output logic      [3:0]          ram_addr_out,                     // Sample slot
  output logic      [SAMPLE_W-1:0] ram_data_out,                     // Sample value
  output logic      [2:0]          link_out,                         // Link drive level
  output logic      [2:0]          link_oe_out,                      // Link drive enable
  output logic                     remote_active_out                 // Remote mode live
);
  localparam mip_state_t ST_RESET = '{phase: ST_START, mux_sel: SLOT_UNUSED,
                                      count: COUNT_MIN, default: '0};

  mip_state_t s;
  mip_state_t next_s;

  logic [2:0]                 rs_valid;
  logic [2:0][SAMPLE_W-1:0]   rs_data;
  logic [3:0]                 cur;

  // Ordered slot list for local conversion
  function automatic logic [15:0][3:0] build_tbl(input logic rmt,
                                                 input logic [3:0] diff);
    logic [15:0][3:0] t;
    int               n;
    t = {16{SLOT_UNUSED}};
    n = 0;
    for (int p = 0; p < 4; p++) begin
      if (!(rmt && p != 0)) begin
        t[n] = 4'(2 * p);
        n++;
        if (!diff[p]) begin
          t[n] = 4'(2 * p + 1);
          n++;
        end
      end
    end
    for (int v = 0; v < 3; v++) begin
      t[n] = SLOT_VOLT0 + 4'(v);
      n++;
    end
    return t;
  endfunction

  // Local converter decimator
  mip_dec_if loc_if ();
  mip_decimator u_loc_dec (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .dec      (loc_if.filter)
  );

  assign cur = s.tbl[s.fidx - 4'h1];

  // Feed converter bits during the state window
  assign loc_if.clear = (s.phase == ST_CONV) && (s.cyc == 7'h0);
  assign loc_if.bit_valid = (s.phase == ST_CONV) && (s.cyc != 7'h0)
                            && (s.cyc <= DEC_LEN);
  assign loc_if.bit_data = adc_bit_in;

  // Dedicated decimators for the remote links
  for (genvar g = 0; g < 3; g++) begin : g_rmt
    mip_dec_if rmt_if ();
    mip_decimator u_rmt_dec (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .dec      (rmt_if.filter)
    );
    assign rmt_if.clear = !s.rmt;
    assign rmt_if.bit_valid = s.rmt && (s.lcyc == LINK_SAMPLE_CYC);
    assign rmt_if.bit_data = s.sync2[g];
    assign rs_valid[g] = rmt_if.sample_valid;
    assign rs_data[g] = rmt_if.sample;
  end

  // Next-state logic of frame, RAM writes and link
  always_comb begin
    logic found;
    found = 1'b0;
    next_s = s;
    next_s.frame_start = 1'b0;
    next_s.wr = 1'b0;
    next_s.sync1 = link_in;
    next_s.sync2 = s.sync1;
    next_s.lcyc = s.lcyc + 4'h1;
    unique case (s.phase)
      ST_START: begin
        next_s.rmt = remote_sensor_select_in;
        next_s.pre = preamp_enable_in;
        next_s.diff = {pair_differential_select_in,
                       first_pair_differential_select_in};
        next_s.count = (mux_state_count_in == 4'h0) ? COUNT_MIN : mux_state_count_in;
        next_s.tbl = build_tbl(remote_sensor_select_in, next_s.diff);
        next_s.fidx = 4'h1;
        next_s.cyc = 7'h0;
        next_s.phase = ST_CONV;
        next_s.frame_start = 1'b1;
      end
      ST_CONV: begin
        next_s.cyc = s.cyc + 7'h1;
        if (s.cyc == STATE_LAST) begin
          next_s.cyc = 7'h0;
          if (s.fidx == s.count) begin
            next_s.phase = ST_START;
          end else begin
            next_s.fidx = s.fidx + 4'h1;
          end
        end
      end
    endcase
    // Local result into its slot
    if (loc_if.sample_valid && (s.phase == ST_CONV) && (cur != SLOT_UNUSED)) begin
      next_s.wr = 1'b1;
      next_s.waddr = cur;
      next_s.wdata = loc_if.sample;
    end
    // Pending remote samples use idle write cycles
    for (int p = 0; p < 3; p++) begin
      if (!next_s.wr && !found && s.pend[p]) begin
        found = 1'b1;
        next_s.wr = 1'b1;
        next_s.waddr = 4'(2 * p + 2);
        next_s.wdata = s.pdata[p];
        next_s.pend[p] = 1'b0;
      end
    end
    // New sample wins over a same-cycle clear
    for (int p = 0; p < 3; p++) begin
      if (rs_valid[p]) begin
        next_s.pend[p] = 1'b1;
        next_s.pdata[p] = rs_data[p];
      end
    end
    // Mux routing for the coming state
    next_s.mux_sel = (next_s.phase == ST_CONV) ? next_s.tbl[next_s.fidx - 4'h1]
                                               : SLOT_UNUSED;
    next_s.mux_diff = (next_s.mux_sel < SLOT_VOLT0) && !next_s.mux_sel[0]
                      && next_s.diff[next_s.mux_sel[2:1]];
    next_s.pre_route = next_s.pre && (next_s.mux_sel[3:1] == 3'h0);
    // Power pulse, downlink bit, then release for the reply
    if (next_s.rmt && (next_s.lcyc < LINK_PULSE_CYC)) begin
      next_s.lout = 3'h7;
      next_s.loe = 3'h7;
    end else if (next_s.rmt && (next_s.lcyc < 4'(2 * LINK_PULSE_CYC))) begin
      next_s.lout = link_command_in;
      next_s.loe = 3'h7;
    end else begin
      next_s.lout = 3'h0;
      next_s.loe = 3'h0;
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign mux_select_out = s.mux_sel;
  assign mux_differential_out = s.mux_diff;
  assign preamp_route_out = s.pre_route;
  assign frame_start_out = s.frame_start;
  assign ram_write_out = s.wr;
  assign ram_addr_out = s.waddr;
  assign ram_data_out = s.wdata;
  assign link_out = s.lout;
  assign link_oe_out = s.loe;
  assign remote_active_out = s.rmt;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  AST_MUX_STEADY: assert property (
    (s.phase == ST_CONV) && (s.cyc != STATE_LAST) |=> $stable(mux_select_out))
    else $error("mux select moved inside a state");

  AST_LOCAL_WRITE: assert property (
    (s.phase == ST_CONV) && (s.cyc == 7'h0) && (cur != SLOT_UNUSED)
    |-> ##66 (ram_write_out && (ram_addr_out == $past(cur, 66))))
    else $error("local sample not written to its slot");

  AST_REMOTE_BYPASS: assert property (
    remote_active_out |-> (mux_select_out < 4'h2) || (mux_select_out > 4'h7))
    else $error("remote pair routed through the mux");

  AST_REMOTE_SLOT: assert property (
    rs_valid[1] && !s.pend[1] && !ram_write_out
    |=> s.pend[1] ##[0:3] (ram_write_out && (ram_addr_out == 4'h4)))
    else $error("remote sample not written directly");

  AST_UPPER_SLOT: assert property (
    ram_write_out && (ram_addr_out < SLOT_VOLT0) && ram_addr_out[0]
    |-> !s.diff[ram_addr_out[2:1]] && !(s.rmt && (ram_addr_out != 4'h1)))
    else $error("upper slot of a paired input written");

  AST_PREAMP: assert property (
    preamp_route_out |-> s.pre && (mux_select_out <= 4'h1))
    else $error("preamp route outside first pair");

  AST_FIRST_DIFF: assert property (
    (mux_select_out == 4'h0) |-> (mux_differential_out == s.diff[0]))
    else $error("first pair mode does not follow its select");

  AST_VOLT_SE: assert property (
    (mux_select_out >= SLOT_VOLT0) |-> !mux_differential_out)
    else $error("voltage input taken as differential");

  AST_LOCAL_IDLE: assert property (
    !remote_active_out |-> (link_oe_out == 3'h0))
    else $error("link driven while pairs are analog");

  AST_POWER_PULSE: assert property (
    remote_active_out && (s.lcyc == 4'h0) |-> (link_oe_out == 3'h7) && (link_out == 3'h7))
    else $error("power pulse missing on the link");

  AST_FRAME_ONE: assert property (
    frame_start_out |-> (s.fidx == 4'h1) ##1 (s.fidx == 4'h1))
    else $error("frame did not start at state one");

  AST_CFG_HOLD: assert property (
    (s.phase == ST_CONV) |=> $stable(s.rmt) && $stable(s.diff) && $stable(s.pre))
    else $error("routing changed inside a frame");
endmodule

// ===== mip_sensor_model.sv
`timescale 1ns/1ps
// Isolated sensor: powered by drive pulses, answers while line is released
module mip_sensor_model (
  input  wire logic       clock_in,     // System clock
  input  wire logic       rst_n_in,     // Async reset, low
  input  wire logic [2:0] drive_in,     // Device drive level
  input  wire logic [2:0] drive_oe_in,  // Device drive enable
  output logic      [2:0] reply_out,    // Reply bit per link
  output logic      [2:0] reply_oe_out  // Reply drive enable
);
  logic [2:0] powered;
  logic [2:0] idx;
  logic [2:0] oe_d;
  // Power store and reply bit index per link
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      powered <= 3'h0;
      idx     <= 3'h0;
      oe_d    <= 3'h0;
    end else begin
      powered <= powered | (drive_oe_in & drive_in);
      oe_d    <= drive_oe_in;
      idx     <= idx ^ (oe_d & ~drive_oe_in);
    end
  end
  // Link 0 all ones, link 1 alternating, link 2 all zeros
  assign reply_oe_out = powered & ~drive_oe_in;
  assign reply_out    = {1'b0, idx[1], 1'b1};
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import mip_pkg::*;
  logic                clock_in, rst_n_in, pre, fdiff, rmt, adc_bit, mdiff, proute, fstart;
  logic                wr, ract, bitv, c_pre, c_fd, c_rmt;
  logic [2:0]          pdiff, lcmd, link_in, link_out, link_oe, rep, rep_oe, last_wire, c_pd;
  logic [3:0]          cnt, msel, waddr, c_cnt;
  logic [SAMPLE_W-1:0] wdata;
  logic [31:0]         rs;
  logic [3:0]          tq[$];
  logic [25:0]         wq[$];
  int                  failures, comparisons, st_idx, sc, fcyc, started, rseen[3];

  mip_input_path dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .preamp_enable_in(pre),
    .first_pair_differential_select_in(fdiff), .pair_differential_select_in(pdiff),
    .remote_sensor_select_in(rmt), .mux_state_count_in(cnt), .adc_bit_in(adc_bit),
    .link_in(link_in), .link_command_in(lcmd), .mux_select_out(msel),
    .mux_differential_out(mdiff), .preamp_route_out(proute), .frame_start_out(fstart),
    .ram_write_out(wr), .ram_addr_out(waddr), .ram_data_out(wdata), .link_out(link_out),
    .link_oe_out(link_oe), .remote_active_out(ract));
  mip_sensor_model model (.clock_in(clock_in), .rst_n_in(rst_n_in), .drive_in(link_out),
    .drive_oe_in(link_oe), .reply_out(rep), .reply_oe_out(rep_oe));

  // Wire level; undriven line shows inverse of last level
  always @* for (int k = 0; k < 3; k++)
    link_in[k] = link_oe[k] ? link_out[k] : (rep_oe[k] ? rep[k] : ~last_wire[k]);
  always @(posedge clock_in) last_wire <= link_in;

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Expected slot order of one frame from latched settings
  task automatic build();
    logic [3:0] l[$];
    int n;
    l.push_back(4'h0);
    if (!c_fd) l.push_back(4'h1);
    for (int k = 1; k < 4; k++) if (!c_rmt) begin
      l.push_back(4'(2 * k));
      if (!c_pd[k-1]) l.push_back(4'(2 * k + 1));
    end
    l.push_back(4'h8);
    l.push_back(4'h9);
    l.push_back(4'ha);
    n = (c_cnt == 4'h0) ? 1 : int'(c_cnt);
    tq.delete();
    for (int i = 0; i < n; i++) tq.push_back(i < l.size() ? l[i] : 4'hf);
  endtask

  function automatic logic ediff(input logic [3:0] s);
    if (s < 4'h2) return c_fd;
    if (s < 4'h8) return c_pd[s[2:1] - 2'h1];
    return 1'b0;
  endfunction

  function automatic logic [21:0] rexp(input int k);
    return (k == 0) ? 22'h000040 : ((k == 1) ? 22'h000000 : 22'h3fffc0);
  endfunction

  // Reference model of frames and sample writes
  always @(negedge clock_in) if (rst_n_in) begin
    fcyc++;
    if (fstart) begin
      if (started) check(fcyc, 1 + tq.size() * 66);
      {c_pre, c_fd, c_pd, c_rmt, c_cnt} = {pre, fdiff, pdiff, rmt, cnt};
      build();
      {st_idx, sc, fcyc, started} = {32'd0, 32'd0, 32'd0, 32'd1};
    end else if (started && ++sc == 66) begin
      sc = 0;
      st_idx++;
    end
    if (started && st_idx < tq.size()) begin
      if (sc == 0) begin
        check(msel, tq[st_idx]);
        if (tq[st_idx] != 4'hf) begin
          check(mdiff, ediff(tq[st_idx]));
          check(proute, c_pre && tq[st_idx] < 4'h2);
        end
        if (!c_rmt) check(link_oe, 3'h0);
        bitv = xs() >> 7;
        adc_bit = bitv;
        lcmd = xs();
      end
      if (sc == 1) check(ract, c_rmt);
      if (sc == 65 && tq[st_idx] != 4'hf)
        wq.push_back({tq[st_idx], bitv ? 22'h000040 : 22'h3fffc0});
    end
    if (wr) begin
      if (wq.size() > 0 && waddr === wq[0][25:22]) begin
        check(wdata, wq[0][21:0]);
        void'(wq.pop_front());
      end else if (ract && waddr inside {4'h2, 4'h4, 4'h6}) begin
        if (++rseen[waddr/2-1] > 2) check(wdata, rexp(waddr/2-1));
      end else check(waddr, 4'hf);
    end
  end

  task automatic frames(input int n);
    repeat (n) begin
      @(negedge clock_in);
      while (!fstart) @(negedge clock_in);
    end
  endtask

  task automatic stop_test();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clock_in = 0;
    forever #20 clock_in = ~clock_in;
  end

  initial begin
    #(60000 * 40);
    failures++;
    stop_test();
  end

  // Settings change mid-frame, then whole frames are checked
  initial begin
    {rst_n_in, pre, fdiff, pdiff, rmt, cnt, adc_bit, lcmd, last_wire} = '0;
    {rs, failures, comparisons, started, fcyc} = {32'd80, 128'd0};
    rseen = '{0, 0, 0};
    repeat (3) @(negedge clock_in);
    rst_n_in = 1;
    for (int i = 0; i < 9; i++) begin
      frames(1);
      repeat (30) @(negedge clock_in);
      {pre, fdiff, pdiff} = xs();
      cnt = (i == 0) ? 4'h0 : ((i == 1) ? 4'hf : xs());
      frames(2);
    end
    frames(1);
    repeat (30) @(negedge clock_in);
    {rmt, fdiff, pre, cnt} = {3'h7, 4'hf};
    frames(8);
    for (int k = 0; k < 3; k++) check(rseen[k] > 2, 1);
    check(wq.size() < 2, 1);
    stop_test();
  end
endmodule
